/* File: logic/crf_pkg.sv */
// Package for the processor register file and address decoder.
// Assumes one 250 MHz clock domain and a classic Wishbone register bus.
`default_nettype none
package crf_pkg;
  // Flag bit positions
  localparam int FLG_NEG = 7;
  localparam int FLG_OVF = 6;
  localparam int FLG_ONE = 5;
  localparam int FLG_BRK = 4;
  localparam int FLG_DEC = 3;
  localparam int FLG_IDIS = 2;
  localparam int FLG_ZERO = 1;
  localparam int FLG_CARRY = 0;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h24;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h8000;
  // Register word offsets on the bus (byte addresses)
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_IDX_X = 8'h04;
  localparam logic [7:0] OFF_IDX_Y = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_SP = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_ADDR = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;
  // Command codes written to the command register
  localparam logic [3:0] CMD_FETCH = 4'h1;
  localparam logic [3:0] CMD_PUSH = 4'h2;
  localparam logic [3:0] CMD_PULL = 4'h3;
  localparam logic [3:0] CMD_IDX_X = 4'h4;
  localparam logic [3:0] CMD_IDX_Y = 4'h5;
  localparam logic [3:0] CMD_BRK = 4'h6;
  localparam logic [3:0] CMD_IRQ_ACK = 4'h7;
  localparam logic [3:0] CMD_RTI = 4'h8;
  // Address map boundaries
  localparam logic [15:0] RAM_LO_END = 16'h007F;
  localparam logic [15:0] RAM_HI_BASE = 16'h0100;
  localparam logic [15:0] RAM_HI_END = 16'h017F;
  localparam logic [15:0] PER_BASE = 16'h00C0;
  localparam logic [15:0] PER_END = 16'h00FF;
  localparam logic [15:0] ROM_BASE = 16'h8000;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  // Address target select
  typedef enum logic [1:0] {
    crf_tgt_none_t_v = 2'b00,
    crf_tgt_ram_v = 2'b01,
    crf_tgt_per_v = 2'b11,
    crf_tgt_rom_v = 2'b10
  } crf_tgt_t;
  // Decoded memory request bundle
  typedef struct packed {
    logic [15:0] addr;
    crf_tgt_t tgt;
    logic [6:0] ram_idx;
  } crf_mreq_t;
endpackage
`default_nettype wire

/* File: logic/crf_core.sv */
// Processor programmer-visible registers and address decoder.
// Assumes a classic Wishbone master on clk_i; bus reset rst_i is already synchronous.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Eight-bit accumulator holds operation results
// - Two index registers add to base address
// - Flag bits sign to carry, bit five one
// - Overflow, zero, carry read one when true
// - Break flag one for break, zero irq
// - Decimal flag selects decimal arithmetic mode
// - Interrupt-disable flag masks maskable request
// - Sixteen-bit counter drives address bytes on fetch
// - Counter increments after every program fetch
// - Stack pointer moves on push, pull, interrupts
// - RAM low window, page-one alias same cell
// - Zero-page C0 to FF reach peripherals
// - ROM at 8000 to FFFF readable
// - Low-voltage detect holds device in reset
// - Accepted interrupt blocks further interrupts
module crf_core import crf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_low_n_i,
  input wire logic low_voltage_reset_i,
  input wire logic maskable_int_request_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] mem_addr_o,
  output logic [1:0] mem_tgt_o,
  output logic [6:0] ram_idx_o,
  output logic decimal_mode_o,
  output logic int_taken_o,
  output logic in_reset_o
);
  logic [7:0] acc;
  logic [7:0] idx_x;
  logic [7:0] idx_y;
  logic [7:0] flags;
  logic [15:0] pc;
  logic [7:0] sp;
  logic [15:0] eff_addr;
  logic int_block;
  logic pin_rst_m;
  logic pin_rst_s;
  logic supply_low_m;
  logic supply_low_s;
  logic irq_m;
  logic irq_s;
  logic core_rst;
  logic wr_stb;
  logic [7:0] reg_off;
  logic [3:0] cmd;
  logic cmd_go;
  logic irq_ok;
  crf_mreq_t next_req;

  // Two-flop synchronisers for pin-level inputs
  always_ff @(posedge clk_i) begin
    pin_rst_m <= ext_reset_low_n_i;
    pin_rst_s <= pin_rst_m;
    supply_low_m <= low_voltage_reset_i;
    supply_low_s <= supply_low_m;
    irq_m <= maskable_int_request_i;
    irq_s <= irq_m;
  end

  // Internal reset: bus reset, low pin, or low supply
  always_comb begin
    core_rst = rst_i | ~pin_rst_s | supply_low_s;
  end

  // Write lands on the edge where the master sees ack, so it lands once
  always_comb begin
    reg_off = wb_adr_i[7:0];
    wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    cmd_go = wr_stb & (reg_off == OFF_CMD);
    cmd = wb_dat_i[3:0];
    irq_ok = irq_s & ~flags[FLG_IDIS] & ~int_block;
  end

  // Bus ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i & wb_stb_i & ~wb_we_i) begin
      case (reg_off)
        OFF_ACC: wb_dat_o <= {24'h000000, acc};
        OFF_IDX_X: wb_dat_o <= {24'h000000, idx_x};
        OFF_IDX_Y: wb_dat_o <= {24'h000000, idx_y};
        OFF_FLAGS: wb_dat_o <= {24'h000000, flags};
        OFF_PC: wb_dat_o <= {16'h0000, pc};
        OFF_SP: wb_dat_o <= {24'h000000, sp};
        OFF_ADDR: wb_dat_o <= {16'h0000, mem_addr_o}; // Last issued address
        OFF_STAT: wb_dat_o <= {29'h0000000, int_block, irq_s, core_rst};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Accumulator and index registers, written by software
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      acc <= REG_RST;
      idx_x <= REG_RST;
      idx_y <= REG_RST;
    end else if (wr_stb) begin
      if (reg_off == OFF_ACC) acc <= wb_dat_i[7:0];
      if (reg_off == OFF_IDX_X) idx_x <= wb_dat_i[7:0];
      if (reg_off == OFF_IDX_Y) idx_y <= wb_dat_i[7:0];
    end
  end

  // Flag register; bit 5 always reads one
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      flags <= FLAGS_RST;
    end else if (wr_stb && reg_off == OFF_FLAGS) begin
      flags <= wb_dat_i[7:0] | (8'h01 << FLG_ONE);
    end else if (cmd_go && cmd == CMD_BRK) begin
      flags[FLG_BRK] <= 1'b1;
      flags[FLG_IDIS] <= 1'b1;
    end else if (cmd_go && cmd == CMD_IRQ_ACK && irq_ok) begin
      flags[FLG_BRK] <= 1'b0;
      flags[FLG_IDIS] <= 1'b1;
    end
  end

  // Block until software clears disable flag
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      int_block <= 1'b0;
    end else if (cmd_go && cmd == CMD_IRQ_ACK && irq_ok) begin
      int_block <= 1'b1;
    end else if (wr_stb && reg_off == OFF_FLAGS && !wb_dat_i[FLG_IDIS]) begin
      int_block <= 1'b0;
    end
  end

  // Program counter: loadable, steps on every fetch
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      pc <= PC_RST;
    end else if (wr_stb && reg_off == OFF_PC) begin
      pc <= wb_dat_i[15:0];
    end else if (cmd_go && cmd == CMD_FETCH) begin
      pc <= pc + 16'h0001;
    end
  end

  // Stack pointer: not reset, software must load it first
  always_ff @(posedge clk_i) begin
    if (wr_stb && reg_off == OFF_SP) begin
      sp <= wb_dat_i[7:0];
    end else if (cmd_go && (cmd == CMD_PUSH || cmd == CMD_BRK)) begin
      sp <= sp - 8'h01;
    end else if (cmd_go && cmd == CMD_IRQ_ACK && irq_ok) begin
      sp <= sp - 8'h01;
    end else if (cmd_go && (cmd == CMD_PULL || cmd == CMD_RTI)) begin
      sp <= sp + 8'h01;
    end
  end

  // Effective address per command; pull uses post-increment slot
  always_comb begin
    next_req = '0;
    eff_addr = {pc[15:8], pc[7:0]};
    case (cmd)
      CMD_IDX_X: eff_addr = wb_dat_i[31:16] + {8'h00, idx_x};
      CMD_IDX_Y: eff_addr = wb_dat_i[31:16] + {8'h00, idx_y};
      CMD_PUSH: eff_addr = {STACK_PAGE, sp};
      CMD_PULL: eff_addr = {STACK_PAGE, sp + 8'h01};
      default: eff_addr = {pc[15:8], pc[7:0]};
    endcase
    next_req.addr = eff_addr;
    next_req.ram_idx = eff_addr[6:0];
    if (eff_addr >= ROM_BASE) begin
      next_req.tgt = crf_tgt_rom_v;
    end else if (eff_addr <= RAM_LO_END) begin
      next_req.tgt = crf_tgt_ram_v;
    end else if (eff_addr >= RAM_HI_BASE && eff_addr <= RAM_HI_END) begin
      next_req.tgt = crf_tgt_ram_v;
    end else if (eff_addr >= PER_BASE && eff_addr <= PER_END) begin
      next_req.tgt = crf_tgt_per_v;
    end else begin
      next_req.tgt = crf_tgt_none_t_v;
    end
  end

  // Memory-side outputs, registered on each command
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      mem_addr_o <= 16'h0000;
      mem_tgt_o <= 2'b00;
      ram_idx_o <= 7'h00;
    end else if (cmd_go) begin
      mem_addr_o <= next_req.addr;
      mem_tgt_o <= next_req.tgt;
      ram_idx_o <= next_req.ram_idx;
    end
  end

  // Status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decimal_mode_o <= 1'b0;
      int_taken_o <= 1'b0;
      in_reset_o <= 1'b1;
    end else begin
      decimal_mode_o <= flags[FLG_DEC];
      int_taken_o <= cmd_go && cmd == CMD_IRQ_ACK && irq_ok;
      in_reset_o <= core_rst;
    end
  end

  // Bus: one answer per request, never held a second cycle
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  // A request with no answer pending is answered on the next edge
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");

  // Accumulator takes the byte written to it
  acc_write_a: assert property (@(posedge clk_i) disable iff (core_rst)
    wr_stb && reg_off == OFF_ACC |=> acc == $past(wb_dat_i[7:0]))
    else $error("accumulator not written");

  // Indexed address is base plus X, wrapping at 16 bits
  idx_add_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_IDX_X |=>
    mem_addr_o == $past(wb_dat_i[31:16]) + {8'h00, $past(idx_x)})
    else $error("indexed address wrong");

  // Bit five can never be cleared, not even by a write
  flag_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[FLG_ONE]) else $error("flag bit five low");

  // Written flags keep every bit, only bit five is forced
  flag_write_a: assert property (@(posedge clk_i) disable iff (core_rst)
    wr_stb && reg_off == OFF_FLAGS |=> flags == ($past(wb_dat_i[7:0]) | 8'h20))
    else $error("flags not written");

  // Break entry sets B and masks further requests
  brk_flag_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_BRK |=> flags[FLG_BRK] && flags[FLG_IDIS])
    else $error("break flag not set");

  // Hardware interrupt entry clears B and sets I
  irq_flags_a: assert property (@(posedge clk_i) disable iff (core_rst)
    int_taken_o |-> !flags[FLG_BRK] && flags[FLG_IDIS])
    else $error("irq entry flags wrong");

  // Decimal mode output follows the D flag one cycle later
  dec_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags[FLG_DEC] |=> decimal_mode_o) else $error("decimal not shown");

  // A set I flag keeps an acknowledge from taking the request
  irq_mask_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_IRQ_ACK && flags[FLG_IDIS] |=> !int_taken_o)
    else $error("masked irq accepted");

  // A loaded counter value appears whole
  pc_load_a: assert property (@(posedge clk_i) disable iff (core_rst)
    wr_stb && reg_off == OFF_PC |=> pc == $past(wb_dat_i[15:0]))
    else $error("pc not loaded");

  // A fetch puts both counter bytes on the address bus
  fetch_addr_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_FETCH |=> mem_addr_o == $past(pc))
    else $error("fetch address wrong");

  // Counter steps by one after each fetch
  pc_step_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_FETCH |=> pc == $past(pc) + 16'h0001)
    else $error("pc did not step");

  // Push moves the pointer down by one
  sp_push_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_PUSH |=> sp == $past(sp) - 8'h01)
    else $error("sp did not drop");

  // Pull moves the pointer up by one
  sp_pull_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_PULL |=> sp == $past(sp) + 8'h01)
    else $error("sp did not rise");

  // Both RAM windows land on the same 128 cells
  alias_ram_a: assert property (@(posedge clk_i) disable iff (core_rst)
    mem_tgt_o == 2'b01 |-> mem_addr_o[6:0] == ram_idx_o && !mem_addr_o[7])
    else $error("ram alias wrong");

  // Peripheral target only inside the zero-page register window
  per_dec_a: assert property (@(posedge clk_i) disable iff (core_rst)
    mem_tgt_o == 2'b11 |-> mem_addr_o[15:6] == 10'h003) else $error("bad periph");

  // ROM target only in the upper half of the map
  rom_dec_a: assert property (@(posedge clk_i) disable iff (core_rst)
    mem_tgt_o == 2'b10 |-> mem_addr_o[15]) else $error("bad rom decode");

  // A low reset pin, once through the two-flop synchroniser, shows in the reset status one cycle later
  pin_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pin_rst_s |=> in_reset_o) else $error("pin reset not held");

  // Low supply holds the core in reset with no software help
  supply_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_low_s |=> in_reset_o) else $error("low supply not held");

  // An accepted interrupt raises the block
  irq_block_a: assert property (@(posedge clk_i) disable iff (core_rst)
    int_taken_o |-> int_block) else $error("no block after irq");

  // While blocked, a further acknowledge is refused
  block_hold_a: assert property (@(posedge clk_i) disable iff (core_rst)
    int_block && cmd_go && cmd == CMD_IRQ_ACK |=> !int_taken_o)
    else $error("blocked irq accepted");

  // Push addresses page one at the current pointer
  stack_push_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_PUSH |=> mem_addr_o == {STACK_PAGE, $past(sp)})
    else $error("push address wrong");

  // Pull addresses page one, one slot above the pointer
  stack_pull_a: assert property (@(posedge clk_i) disable iff (core_rst)
    cmd_go && cmd == CMD_PULL |=> mem_addr_o == {STACK_PAGE, $past(sp) + 8'h01})
    else $error("pull address wrong");

  // Main scenarios, each to be seen at least once
  cov_fetch_c: cover property (@(posedge clk_i) cmd_go && cmd == CMD_FETCH);
  cov_irq_c: cover property (@(posedge clk_i) int_taken_o);
  cov_alias_c: cover property (@(posedge clk_i) mem_addr_o[8] && mem_tgt_o == 2'b01);
  cov_brk_c: cover property (@(posedge clk_i) cmd_go && cmd == CMD_BRK);
  cov_pin_rst_c: cover property (@(posedge clk_i) !rst_i && in_reset_o);
endmodule // crf_core
`default_nettype wire

/* File: tb/crf_mem_model.sv */
// Memory-side model: which store answers a core address, and which cell.
// Assumes it only watches the decoded address; no data moves here.
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model import crf_pkg::*; (
  input wire logic [15:0] mem_addr_i,
  output logic [1:0] region_o,
  output logic [6:0] cell_o
);
  // Both RAM windows fold onto the same 128 cells
  always_comb begin
    cell_o = mem_addr_i[6:0];
    region_o = crf_tgt_none_t_v;
    if (mem_addr_i >= ROM_BASE) begin
      region_o = crf_tgt_rom_v;
    end else if (mem_addr_i >= PER_BASE && mem_addr_i <= PER_END) begin
      region_o = crf_tgt_per_v;
    end else if (mem_addr_i <= RAM_LO_END) begin
      region_o = crf_tgt_ram_v;
    end else if (mem_addr_i >= RAM_HI_BASE && mem_addr_i <= RAM_HI_END) begin
      region_o = crf_tgt_ram_v;
    end
  end
endmodule // crf_mem_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the register file and address decoder.
// Assumes crf_core on a 4 ns clock, Wishbone answered in one cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb import crf_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ext_reset_low_n_i = 1'b1;
  logic low_voltage_reset_i = 1'b0;
  logic maskable_int_request_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, v, e;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0] n_int = 8'h00, k;
  logic wb_ack_o, decimal_mode_o, int_taken_o, in_reset_o;
  logic [15:0] mem_addr_o, b;
  logic [1:0] mem_tgt_o, exp_tgt;
  logic [6:0] ram_idx_o, exp_idx;
  logic [7:0] fl = FLAGS_RST;
  logic [31:0] exp_q[$];
  logic [15:0] bases [11] = '{16'h0000, 16'h007F, 16'h0080, 16'h00BF, 16'h00C0, 16'h00FF,
    16'h0100, 16'h017F, 16'h0180, 16'h7FFF, 16'h8000};
  int n_errors = 0, check_count = 0;
  always #2 clk_i = ~clk_i;
  crf_core crf_core_inst (.clk_i, .rst_i, .ext_reset_low_n_i, .low_voltage_reset_i,
    .maskable_int_request_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .mem_addr_o, .mem_tgt_o, .ram_idx_o,
    .decimal_mode_o, .int_taken_o, .in_reset_o);
  crf_mem_model crf_mem_model_inst (.mem_addr_i(mem_addr_o), .region_o(exp_tgt),
    .cell_o(exp_idx));
  // Read answers are paired with the oldest note, in order
  always @(posedge clk_i) begin
    if (int_taken_o) n_int <= n_int + 8'h01;
    if (wb_ack_o && !wb_we_i) begin
      e = exp_q.pop_front();
      `CHK(wb_dat_o, e)
    end
  end
  // One classic cycle; held until ack is sampled high
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i iff wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(a, 32'h0, 1'b0);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] base);
    wr(OFF_CMD, {base, 12'h0, c});
  endtask
  // Cell index only matters when RAM answers
  task automatic chkm(input logic [15:0] a);
    `CHK(mem_addr_o, a)
    `CHK(mem_tgt_o, exp_tgt)
    if (exp_tgt === 2'b01) `CHK(ram_idx_o, exp_idx)
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles of the run
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end
  initial begin
    v = $urandom(91058);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(OFF_FLAGS, {24'h0, FLAGS_RST});
    rd(OFF_PC, {16'h0, PC_RST});
    rd(8'h24, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      if (i % 4 == 3) fl = v[7:0] | 8'h20;
      wr(8'(4 * (i % 4)), v);
      rd(8'(4 * (i % 4)), {24'h0, (i % 4 == 3) ? fl : v[7:0]});
      `CHK(decimal_mode_o, fl[FLG_DEC])
    end
    $display("test registers done");
    wr(OFF_PC, 32'h0000FFFF);
    cmd(CMD_FETCH, 16'h0);
    chkm(16'hFFFF);
    rd(OFF_PC, 32'h0);
    cmd(CMD_FETCH, 16'h0);
    chkm(16'h0000);
    rd(OFF_PC, 32'h1);
    $display("test fetch done");
    wr(OFF_IDX_X, 32'h0);
    foreach (bases[i]) begin
      cmd(CMD_IDX_X, bases[i]);
      chkm(bases[i]);
    end
    v = $urandom();
    b = v[31:16];
    wr(OFF_IDX_Y, v);
    cmd(CMD_IDX_Y, b);
    chkm(b + {8'h0, v[7:0]});
    rd(OFF_ADDR, {16'h0, b + {8'h0, v[7:0]}});
    $display("test decode done");
    wr(OFF_SP, 32'h0);
    cmd(CMD_PUSH, 16'h0);
    chkm(16'h0100);
    rd(OFF_SP, 32'hFF);
    cmd(CMD_PULL, 16'h0);
    chkm(16'h0100);
    rd(OFF_SP, 32'h0);
    wr(OFF_FLAGS, 32'h0);
    cmd(CMD_BRK, 16'h0);
    rd(OFF_FLAGS, 32'h34);
    cmd(CMD_RTI, 16'h0);
    rd(OFF_SP, 32'h0);
    $display("test stack done");
    maskable_int_request_i <= 1'b1;
    wr(OFF_FLAGS, 32'h04);
    k = n_int;
    cmd(CMD_IRQ_ACK, 16'h0);
    repeat (2) @(posedge clk_i);
    `CHK(n_int, k)
    wr(OFF_FLAGS, 32'h0);
    cmd(CMD_IRQ_ACK, 16'h0);
    repeat (2) @(posedge clk_i);
    `CHK(n_int, k + 8'h01)
    rd(OFF_FLAGS, 32'h24);
    cmd(CMD_IRQ_ACK, 16'h0);
    repeat (2) @(posedge clk_i);
    `CHK(n_int, k + 8'h01)
    rd(OFF_STAT, 32'h6);
    maskable_int_request_i <= 1'b0;
    $display("test interrupt done");
    wr(OFF_ACC, 32'h5A);
    ext_reset_low_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK(in_reset_o, 1'b1)
    ext_reset_low_n_i <= 1'b1;
    low_voltage_reset_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    `CHK(in_reset_o, 1'b1)
    low_voltage_reset_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK(in_reset_o, 1'b0)
    rd(OFF_ACC, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
